// ---- core/ais_core.sv ----
// Analog input scaling: offset, multiply, divide of raw converter counts.
// Assumes raw counts and their strobes are synchronous to sys_clk; AXI4-Lite slave.
//
// Contract
// - Offset is added to the raw count before multiply and divide.
// - Offset-corrected count is multiplied by the signed multiplier.
// - The product is divided by the signed divisor to give the value.
// - Default offset, multiplier and divisor publish the raw count unchanged.
// - Input one value is signed 32-bit read-only, zero after reset.
// - Subindex zero of each group reads the input count, read-only.
// - Input one offset is signed 16-bit read/write, reset zero.
// - Input one multiplier is signed 16-bit read/write, reset one.
// - Input one divisor is signed 16-bit read/write entry.
// - Optional second input uses subindex two of every group.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "ais_defines.svh"

module ais_core #(
	parameter int INPUTS  = 1,
	parameter int RAW_W   = 10
) (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	// Converter samples
	input  wire logic [1:0]                raw_valid,
	input  wire logic [1:0][RAW_W-1:0]     raw_count,
	// AXI4-Lite write address
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [`AIS_ADDR_W-1:0]    s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	// AXI4-Lite write response
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic [1:0]                     s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [`AIS_ADDR_W-1:0]    s_axi_araddr,
	// AXI4-Lite read data
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	// Status
	output ais_pkg::ais_calc_t             calc_state
);
	import ais_pkg::*;

	ais_scale_t         scale_ff [2];
	logic signed [31:0] value_ff [2];
	ais_calc_t          state_ff;
	logic               sel_ff;
	logic signed [32:0] sum_ff;
	logic signed [48:0] prod_ff;
	logic [1:0]         pend_ff;
	logic [RAW_W-1:0]   pend_raw_ff [2];

	ais_word_t          aw_ff;
	logic               aw_full_ff;
	logic               w_full_ff;
	logic [3:0]         wstrb_ff;

	// Decode result: {hit, entry}; entry 0..3 group, sub in low part
	function automatic logic [4:0] decode(input logic [`AIS_ADDR_W-1:0] a);
		logic [15:0] idx;
		logic [3:0]  sub;
		logic        aligned;
		logic        fitted;
		logic        in_range;
		idx      = a[`AIS_ADDR_W-1:`AIS_IDX_LSB];
		sub      = a[`AIS_IDX_LSB-1:`AIS_SUB_LSB];
		aligned  = (a[1:0] == 2'b00);
		// Subindex above the fitted inputs is refused, never folded onto another
		fitted   = (int'(sub) <= INPUTS);
		in_range = (idx >= `AIS_IDX_VALUE) && (idx <= `AIS_IDX_DIV);
		decode   = {aligned && fitted && in_range, 2'(idx - `AIS_IDX_VALUE), sub[1:0]};
	endfunction

	// Byte strobes 0 and 1 cover the 16-bit entry; the upper two are ignored
	function automatic logic [15:0] merge16(input logic [15:0] old,
	                                        input logic [31:0] d,
	                                        input logic [3:0]  s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Subindex one is input 0, subindex two is input 1
	function automatic logic input_of(input logic [4:0] dec);
		input_of = (dec[1:0] == 2'd1) ? 1'b0 : 1'b1;
	endfunction

	// Only the offset, multiplier and divisor of a fitted input take writes
	function automatic logic writable(input logic [4:0] dec);
		writable = dec[4] && (dec[1:0] != 2'd0) && (dec[3:2] != 2'd0);
	endfunction

	// Read word of a decoded entry; counts and refusals are handled by the caller
	function automatic logic [31:0] entry_word(input logic [4:0] dec);
		logic ix;
		ix = input_of(dec);
		case (dec[3:2])
			2'd0:    entry_word = value_ff[ix];
			2'd1:    entry_word = 32'(scale_ff[ix].offset);
			2'd2:    entry_word = 32'(scale_ff[ix].mult);
			2'd3:    entry_word = 32'(scale_ff[ix].div);
			default: entry_word = 32'h0000_0000;
		endcase
	endfunction

	// Raw count is unsigned; a signed offset may take the sum below zero
	function automatic logic signed [32:0] offset_sum(input logic [RAW_W-1:0]   raw,
	                                                 input logic signed [15:0] off);
		offset_sum = 33'($signed({1'b0, raw})) + 33'(off);
	endfunction

	// Wide enough for the worst product, so nothing is lost before the divide
	function automatic logic signed [48:0] scaled_product(input logic signed [32:0] sum,
	                                                     input logic signed [15:0] mul);
		scaled_product = 49'(sum * mul);
	endfunction

	// Truncates toward zero; the quotient is cut to the published word
	function automatic logic signed [31:0] scaled_quotient(input logic signed [48:0] prod,
	                                                      input logic signed [15:0] div);
		scaled_quotient = 32'(prod / div);
	endfunction

	// Write channel capture, address and data in either order
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_full_ff <= 1'b0;
			w_full_ff  <= 1'b0;
			aw_ff      <= '0;
			wstrb_ff   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_ff   <= 1'b1;
				aw_ff.addr   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_ff    <= 1'b1;
				aw_ff.data   <= s_axi_wdata;
				wstrb_ff     <= s_axi_wstrb;
			end
			// Both halves free again once the write is committed
			if (aw_full_ff && w_full_ff) begin
				aw_full_ff <= 1'b0;
				w_full_ff  <= 1'b0;
			end
		end
	end

	// Ready lines are registered so the outputs come from flip-flops
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			s_axi_awready <= 1'b0;
		else
			s_axi_awready <= !aw_full_ff && !(s_axi_awvalid && s_axi_awready) &&
			                 !s_axi_bvalid;
	end

	// Held low while a response waits, so one write at most is under way
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			s_axi_wready <= 1'b0;
		else
			s_axi_wready <= !w_full_ff && !(s_axi_wvalid && s_axi_wready) &&
			                !s_axi_bvalid;
	end

	// Write commit and response
	always_ff @(posedge sys_clk) begin
		logic [4:0] dec;
		logic       ix;
		dec = decode(aw_ff.addr);
		ix  = input_of(dec);
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AIS_RESP_OKAY;
			for (int i = 0; i < 2; i++) begin
				scale_ff[i].offset <= `AIS_RST_OFFSET;
				scale_ff[i].mult   <= `AIS_RST_MULT;
				scale_ff[i].div    <= `AIS_RST_DIV;
			end
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_full_ff && w_full_ff) begin
				s_axi_bvalid <= 1'b1;
				// Value, counts and unmapped words refuse writes
				s_axi_bresp  <= `AIS_RESP_SLVERR;
				if (writable(dec)) begin
					s_axi_bresp <= `AIS_RESP_OKAY;
					case (dec[3:2])
						2'd1: scale_ff[ix].offset <= merge16(scale_ff[ix].offset,
						                                     aw_ff.data, wstrb_ff);
						2'd2: scale_ff[ix].mult   <= merge16(scale_ff[ix].mult,
						                                     aw_ff.data, wstrb_ff);
						2'd3: scale_ff[ix].div    <= merge16(scale_ff[ix].div,
						                                     aw_ff.data, wstrb_ff);
						default: s_axi_bresp <= `AIS_RESP_SLVERR;
					endcase
				end
			end
		end
	end

	// Address ready drops while a read answer waits
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
	end

	// Read path, one cycle latency after the address is taken
	always_ff @(posedge sys_clk) begin
		logic [4:0] dec;
		dec = decode(s_axi_araddr);
		if (sys_rst) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `AIS_RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= dec[4] ? `AIS_RESP_OKAY : `AIS_RESP_SLVERR;
				// Refused reads return zero, so no stale word leaks out
				s_axi_rdata  <= 32'h0000_0000;
				if (dec[4]) begin
					if (dec[1:0] == 2'd0) begin
						s_axi_rdata <= 32'(INPUTS);
					end else begin
						s_axi_rdata <= entry_word(dec);
					end
				end
			end
		end
	end

	// Pending samples, one slot per input
	// An unserved sample is overwritten by a newer one of the same input
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pend_ff        <= 2'b00;
			pend_raw_ff[0] <= '0;
			pend_raw_ff[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				// New sample wins over the clear of a consumed one
				if (state_ff == AIS_CALC_IDLE && pend_ff[i] && sel_ff == 1'(i))
					pend_ff[i] <= 1'b0;
				if (raw_valid[i] && i < INPUTS) begin
					pend_ff[i]     <= 1'b1;
					pend_raw_ff[i] <= raw_count[i];
				end
			end
		end
	end

	// Conversion sequence, inputs served alternately
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_ff <= AIS_CALC_IDLE;
		end else begin
			case (state_ff)
				AIS_CALC_IDLE: begin
					// Fixed four steps a sample, so a waiting input loses one turn at most
					if (pend_ff[sel_ff])
						state_ff <= AIS_CALC_MUL;
				end
				AIS_CALC_MUL:  state_ff <= AIS_CALC_DIV;
				AIS_CALC_DIV:  state_ff <= AIS_CALC_DONE;
				AIS_CALC_DONE: state_ff <= AIS_CALC_IDLE;
				default:       state_ff <= AIS_CALC_IDLE;
			endcase
		end
	end

	// Datapath registers follow the sequence one step at a time
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sum_ff      <= '0;
			prod_ff     <= '0;
			value_ff[0] <= `AIS_RST_VALUE;
			value_ff[1] <= `AIS_RST_VALUE;
		end else begin
			if (state_ff == AIS_CALC_IDLE && pend_ff[sel_ff])
				sum_ff <= offset_sum(pend_raw_ff[sel_ff], scale_ff[sel_ff].offset);
			if (state_ff == AIS_CALC_MUL)
				prod_ff <= scaled_product(sum_ff, scale_ff[sel_ff].mult);
			// zero divisor keeps the old value
			if (state_ff == AIS_CALC_DIV && scale_ff[sel_ff].div != 16'sh0000)
				// signed divide; defaults pass the raw count
				value_ff[sel_ff] <= scaled_quotient(prod_ff, scale_ff[sel_ff].div);
		end
	end

	// Round-robin pointer: moves on when idle with nothing waiting, or when done
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sel_ff <= 1'b0;
		end else if (INPUTS > 1) begin
			if ((state_ff == AIS_CALC_IDLE && !pend_ff[sel_ff]) ||
			    state_ff == AIS_CALC_DONE)
				sel_ff <= !sel_ff;
		// One input fitted: the pointer stays on it
		end else begin
			sel_ff <= 1'b0;
		end
	end

	// Status copy lags the sequence by one cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			calc_state <= AIS_CALC_IDLE;
		else
			calc_state <= state_ff;
	end

endmodule // ais_core

// ---- core/ais_defines.svh ----
// Constants for the analog input scaling block: register map, fields, resets.
// Assumes inclusion by the package, the core module and the testbench.
`ifndef AIS_DEFINES_SVH
`define AIS_DEFINES_SVH

// Object indices of the four entry groups
`define AIS_IDX_VALUE        16'h3320
`define AIS_IDX_OFFSET       16'h3321
`define AIS_IDX_MULT         16'h3322
`define AIS_IDX_DIV          16'h3323
// Byte address = {index, subindex[3:0], 2'b00}
`define AIS_SUB_LSB          2
`define AIS_SUB_W            4
`define AIS_IDX_LSB          6
`define AIS_ADDR_W           22

// Reset values
`define AIS_RST_VALUE        32'h0000_0000
`define AIS_RST_OFFSET       16'h0000
`define AIS_RST_MULT         16'h0001
`define AIS_RST_DIV          16'h0001
`define AIS_INPUT_MAX        2

// Bus responses
`define AIS_RESP_OKAY        2'b00
`define AIS_RESP_SLVERR      2'b10

`endif

// ---- core/ais_pkg.sv ----
// Types for the analog input scaling block.
// Assumes ais_defines.svh is on the include path.
`include "ais_defines.svh"

package ais_pkg;

	typedef struct packed {
		logic signed [15:0] offset;
		logic signed [15:0] mult;
		logic signed [15:0] div;
	} ais_scale_t;

	typedef enum logic [1:0] {
		AIS_CALC_IDLE = 2'b00,
		AIS_CALC_MUL  = 2'b01,
		AIS_CALC_DIV  = 2'b10,
		AIS_CALC_DONE = 2'b11
	} ais_calc_t;

	typedef struct packed {
		logic [`AIS_ADDR_W-1:0] addr;
		logic [31:0]            data;
	} ais_word_t;

endpackage

// ---- dv/ais_core_checker.sv ----
// Checker for ais_core: bus answer timing and calculation sequencing.
// Assumes it is bound to ais_core and sees only that module's ports.
`timescale 1ns/1ps

module ais_core_checker (
	// Clock and reset
	input wire logic               sys_clk,
	input wire logic               sys_rst,
	// Samples and status
	input wire logic [1:0]         raw_valid,
	input wire ais_pkg::ais_calc_t calc_state,
	// Bus
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic [31:0]        s_axi_rdata,
	input wire logic [1:0]         s_axi_rresp
);
	import ais_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	property p_rst_quiet;
		$fell(sys_rst) |-> !s_axi_rvalid && !s_axi_bvalid && calc_state == AIS_CALC_IDLE;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rd_excl;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rd_excl: assert property (p_rd_excl) else $error("read taken while busy");
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0000_0000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("refused read has data");
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	property p_wr_excl;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_excl: assert property (p_wr_excl) else $error("write taken while busy");
	property p_calc_start;
		|raw_valid && calc_state == AIS_CALC_IDLE |-> ##[1:4] calc_state != AIS_CALC_IDLE;
	endproperty
	a_calc_start: assert property (p_calc_start) else $error("sample ignored");
	property p_calc_order;
		calc_state == AIS_CALC_MUL |=> calc_state inside {AIS_CALC_MUL, AIS_CALC_DIV};
	endproperty
	a_calc_order: assert property (p_calc_order) else $error("divide skipped");
	property p_calc_end;
		calc_state != AIS_CALC_IDLE |-> ##[1:16] calc_state == AIS_CALC_IDLE;
	endproperty
	a_calc_end: assert property (p_calc_end) else $error("calculation hung");
endmodule // ais_core_checker

bind ais_core ais_core_checker u_chk (.*);

// ---- dv/test_analog_input_scaling.sv ----
// Testbench for ais_core: register map, refusals, scaling against a model.
// Assumes core, package and checker are compiled before this file.
`timescale 1ns/1ps
`include "ais_defines.svh"

module test_analog_input_scaling;
	import ais_pkg::*;
	localparam int NIN = 2;
	logic             sys_clk = 1'b0;
	logic             sys_rst = 1'b1;
	logic [1:0]       rvl = 2'h0;
	logic [1:0][9:0]  rcnt = '0;
	logic             awv = 1'b0;
	logic             wv = 1'b0;
	logic             arv = 1'b0;
	logic             rdy = 1'b1;
	logic [21:0]      awa = 22'h0_0000;
	logic [21:0]      ara = 22'h0_0000;
	logic [31:0]      wd = 32'h0000_0000;
	logic [31:0]      rd;
	logic             awr, wrdy, bv, arr, rv;
	logic [1:0]       br, rr;
	ais_calc_t        cs;
	int               n_mismatch = 0;
	int               samples_checked = 0;
	// Model of the parameter and value entries
	int               off[2] = '{0, 0};
	int               mul[2] = '{1, 1};
	int               dv[2] = '{1, 1};
	int               val[2] = '{0, 0};

	ais_core #(.INPUTS(NIN), .RAW_W(10)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .raw_valid(rvl), .raw_count(rcnt),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bv), .s_axi_bready(rdy), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rdy), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.calc_state(cs));

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic stuck();
		n_mismatch++;
		wrap_up();
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	function automatic logic [21:0] ad(input int idx, input int sub);
		return 22'(idx * 64 + sub * 4);
	endfunction

	task automatic bus_wr(input logic [21:0] a, input logic [31:0] d, input logic [1:0] e);
		int k;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge sys_clk);
			if (awr)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
			if (bv)
				break;
		end
		if (k == 64)
			stuck();
		chk(32'(br), 32'(e));
	endtask

	task automatic bus_rd(input logic [21:0] a, input logic [31:0] e, input logic [1:0] er);
		int k;
		ara <= a;
		arv <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge sys_clk);
			if (arr)
				arv <= 1'b0;
			if (rv)
				break;
		end
		if (k == 64)
			stuck();
		chk(rd, e);
		chk(32'(rr), 32'(er));
	endtask

	task automatic prm(input int g, input int i, input logic [15:0] h, output int m);
		m = $signed(h);
		bus_wr(ad(g, i + 1), {16'($urandom), h}, `AIS_RESP_OKAY);
		bus_rd(ad(g, i + 1), 32'(m), `AIS_RESP_OKAY);
	endtask

	task automatic smp(input int i, input int r);
		int k;
		longint p;
		rcnt[i] <= 10'(r);
		rvl[i] <= 1'b1;
		@(posedge sys_clk);
		rvl[i] <= 1'b0;
		for (k = 0; k < 8 && cs == AIS_CALC_IDLE; k++)
			@(posedge sys_clk);
		if (k == 8)
			stuck();
		for (k = 0; k < 64 && cs != AIS_CALC_IDLE; k++)
			@(posedge sys_clk);
		if (k == 64)
			stuck();
		p = (longint'(r) + off[i]) * mul[i];
		// Zero divisor keeps the old value
		if (dv[i] != 0)
			val[i] = int'(p / dv[i]);
		bus_rd(ad(`AIS_IDX_VALUE, i + 1), val[i], `AIS_RESP_OKAY);
	endtask

	initial begin
		int i;
		int k;
		void'($urandom(25));
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (k = 0; k < 4; k++)
			bus_rd(ad(`AIS_IDX_VALUE + k, 0), NIN, `AIS_RESP_OKAY);
		for (i = 1; i <= NIN; i++) begin
			bus_rd(ad(`AIS_IDX_VALUE, i), 32'h0000_0000, `AIS_RESP_OKAY);
			bus_rd(ad(`AIS_IDX_OFFSET, i), 32'h0000_0000, `AIS_RESP_OKAY);
			bus_rd(ad(`AIS_IDX_MULT, i), 32'h0000_0001, `AIS_RESP_OKAY);
			bus_rd(ad(`AIS_IDX_DIV, i), 32'h0000_0001, `AIS_RESP_OKAY);
		end
		$display("test reset values done");
		bus_rd(ad(`AIS_IDX_DIV, NIN + 1), 32'h0000_0000, `AIS_RESP_SLVERR);
		bus_rd(22'h0_0000, 32'h0000_0000, `AIS_RESP_SLVERR);
		bus_wr(ad(`AIS_IDX_VALUE, 1), 32'h0000_1234, `AIS_RESP_SLVERR);
		bus_rd(ad(`AIS_IDX_VALUE, 1), 32'h0000_0000, `AIS_RESP_OKAY);
		bus_wr(ad(`AIS_IDX_MULT, 0), 32'h0000_0005, `AIS_RESP_SLVERR);
		bus_rd(ad(`AIS_IDX_MULT, 0), NIN, `AIS_RESP_OKAY);
		$display("test refusals done");
		smp(0, 1023);
		chk(32'(rd * 10000 / 1023), 32'h0000_2710);
		chk(32'(rd * 20000 / 1023), 32'h0000_4e20);
		smp(1, 517);
		$display("test defaults done");
		for (k = 0; k < 24; k++) begin
			i = $urandom % 2;
			prm(`AIS_IDX_OFFSET, i, 16'($urandom), off[i]);
			prm(`AIS_IDX_MULT, i, 16'($urandom), mul[i]);
			prm(`AIS_IDX_DIV, i, ($urandom % 4 == 0) ? 16'h0000 : 16'($urandom), dv[i]);
			smp(i, $urandom % 1024);
		end
		$display("test scaling done");
		wrap_up();
	end
endmodule // test_analog_input_scaling
